//--- common/pfi_pkg.sv
// Purpose: Shared constants for the peripheral interrupt flag block.
// Assumes: Wishbone classic slave with 32-bit data; each register is one aligned word.
// Notes: Register indices are multiplied by four to form byte addresses.

package pfi_pkg;

	// ----------------------------------------------------------------------
	// Register indices and bus layout.
	// ----------------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] IDX_FLAGS_ONE = 8'h0c;
	localparam logic [ADR_W-1:0] IDX_FLAGS_TWO = 8'h0d;
	localparam logic [ADR_W-1:0] IDX_ENABLES_ONE = 8'h8c;
	localparam logic [ADR_W-1:0] IDX_ENABLES_TWO = 8'h8d;
	localparam logic [ADR_W-1:0] IDX_EVT_STATUS = 8'h90;
	localparam logic [ADR_W-1:0] IDX_EVT_ENABLE = 8'h91;
	localparam logic [ADR_W-1:0] IDX_EVT_CLEAR = 8'h92;
	localparam int ADR_LSB = 2;

	// ----------------------------------------------------------------------
	// Field positions inside the first flag register.
	// ----------------------------------------------------------------------
	localparam int BIT_WIDE_OVF = 0;
	localparam int BIT_PERIOD = 1;
	localparam int BIT_CAPCOMP1 = 2;
	localparam int BIT_SERIAL = 3;
	localparam int BIT_UART_TX = 4;
	localparam int BIT_UART_RX = 5;
	localparam int BIT_CONV = 6;
	localparam int BIT_SLAVE = 7;

	// Field position inside the second flag and enable registers.
	localparam int BIT_CAPCOMP2 = 0;

	// Event status register: the eight first-register sources, then the second unit.
	localparam int EVT_W = 9;
	localparam int BIT_EVT_CAPCOMP2 = 8;

	// ----------------------------------------------------------------------
	// Widths and reset values.
	// ----------------------------------------------------------------------
	localparam int REG_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;
	localparam logic [REG_W-1:0] ENABLES_RESET = 8'h00;
	localparam logic [EVT_W-1:0] EVT_RESET = 9'h000;
	localparam logic [REG_W-1:0] FLAGS_TWO_MASK = 8'h01;
	localparam logic [REG_W-1:0] SW_CLEARED_MASK = 8'hcf;
	localparam logic [REG_W-1:0] SLAVE_MASK = 8'h80;
	localparam logic [REG_W-1:0] UART_MASK = 8'h30;
	localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;

endpackage : pfi_pkg

//--- design/pfi_sticky_flags.sv
// Purpose: A vector of sticky flags that hardware sets and software loads.
// Assumes: Set and load inputs come from logic on the same clock.
// Notes: A set in the cycle of a software load wins, so no event is lost.

`timescale 1ns/10ps

module pfi_sticky_flags #(
	parameter int W = 8
) (
	input wire logic clk, // Core clock.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic [W-1:0] setVec, // Per-bit set pulses from hardware.
	input wire logic [W-1:0] implMask, // Bits that exist; others stay zero.
	input wire logic loadEn, // Software write strobe.
	input wire logic [W-1:0] loadMask, // Bits the write may change.
	input wire logic [W-1:0] loadVal, // Value written by software.
	output logic [W-1:0] flags // Current flag state.
);

	logic [W-1:0] flags_reg;
	logic [W-1:0] flags_next;

	// Load written bits first, then let hardware sets override them.
	always_comb begin
		flags_next = flags_reg;
		if (loadEn) begin
			flags_next = (flags_reg & ~loadMask) | (loadVal & loadMask);
		end
		flags_next = (flags_next | setVec) & implMask;
	end

	// Flags hold until cleared and reset to zero.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags = flags_reg;

endmodule : pfi_sticky_flags

//--- design/pfi_irq_gate.sv
// Purpose: Registered interrupt line from flag and enable vectors.
// Assumes: All inputs are on the core clock.
// Notes: The output is a level that follows its inputs one cycle late.

`timescale 1ns/10ps

module pfi_irq_gate #(
	parameter int W = 8
) (
	input wire logic clk, // Core clock.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic [W-1:0] pending, // Pending flags.
	input wire logic [W-1:0] enables, // Matching enable bits.
	output logic irq // Registered request, active high.
);

	logic irq_reg;

	// Request while any flag meets its enable.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(pending & enables);
		end
	end

	assign irq = irq_reg;

endmodule : pfi_irq_gate

//--- design/pfi_peripheral_interrupt_flags.sv
// Purpose: Peripheral interrupt flag registers with a Wishbone classic slave.
// Assumes: Event inputs are one-cycle pulses or levels from logic on clk.
// Notes: Rules are listed below.
// Function
// - Flags set on their events regardless of any enable bit.
// - Conversion-done flag sets at conversion end, held until software clears.
// - Serial-port flag sets on transfer end, cleared only by software.
// - First capture/compare flag sets on capture or match, unused in PWM.
// - Period-match flag sets when short timer equals period, software clears.
// - Wide timer overflow flag sets on overflow, software clears.
// - Slave-port flag sets after external access, software clears it.
// - Receive flag is read-only, high while receive buffer holds data.
// - Transmit flag is read-only, high while transmit buffer is empty.
// - Without slave port and uart, bits seven, five, four read zero.
// - Second flag register: only bit zero, second unit capture or compare.
// - Second enable register holds the second unit's enable bit.
// - All flags, including uart ones, reset to zero.
// - Each first-register flag has a matching enable bit in the first enable register.

`timescale 1ns/10ps

module pfi_peripheral_interrupt_flags #(
	parameter bit HAS_SLAVE_PORT = 1'b1,
	parameter bit HAS_UART = 1'b1
) (
	input wire logic clk, // Core clock, 250 MHz.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [pfi_pkg::ADR_W+1:0] wb_adr_i, // Byte address.
	input wire logic [pfi_pkg::SEL_W-1:0] wb_sel_i, // Byte lane selects.
	input wire logic [pfi_pkg::DAT_W-1:0] wb_dat_i, // Write data.
	output logic [pfi_pkg::DAT_W-1:0] wb_dat_o, // Read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	input wire logic convDoneEvt, // Conversion finished pulse.
	input wire logic serialDoneEvt, // Serial port transfer finished pulse.
	input wire logic capComp1Evt, // First capture/compare event pulse.
	input wire logic capComp1Pwm, // First unit is in PWM mode.
	input wire logic periodMatchEvt, // Short timer equals its period pulse.
	input wire logic wideOverflowEvt, // Wide timer overflow pulse.
	input wire logic slavePortAccessEvt, // External slave-port access pulse.
	input wire logic uartRxFull, // Receive buffer holds data, level.
	input wire logic uartTxEmpty, // Transmit buffer empty, level.
	input wire logic capComp2Evt, // Second capture/compare event pulse.
	input wire logic capComp2Pwm, // Second unit is in PWM mode.
	output logic periphIrq, // Peripheral interrupt request, level.
	output logic eventIrq // Event status interrupt, level.
);

	// ----------------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------------
	// Expand byte selects into a bit mask for the whole word.
	function automatic logic [pfi_pkg::DAT_W-1:0] laneMask(input logic [pfi_pkg::SEL_W-1:0] sel);
		logic [pfi_pkg::DAT_W-1:0] m;
		m = pfi_pkg::DAT_ZERO;
		for (int i = 0; i < pfi_pkg::SEL_W; i++) begin
			m[i*pfi_pkg::REG_W +: pfi_pkg::REG_W] = {pfi_pkg::REG_W{sel[i]}};
		end
		return m;
	endfunction : laneMask

	// Implemented bits of the first flag register for this variant.
	function automatic logic [pfi_pkg::REG_W-1:0] implOne(input bit hasSlave, input bit hasUart);
		logic [pfi_pkg::REG_W-1:0] m;
		m = pfi_pkg::SW_CLEARED_MASK & ~pfi_pkg::SLAVE_MASK;
		if (hasSlave) begin
			m = m | pfi_pkg::SLAVE_MASK;
		end
		if (hasUart) begin
			m = m | pfi_pkg::UART_MASK;
		end
		return m;
	endfunction : implOne

	localparam logic [pfi_pkg::REG_W-1:0] IMPL_ONE = implOne(HAS_SLAVE_PORT, HAS_UART);

	// ----------------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------------
	logic busReq;
	logic wrStrobe;
	logic [pfi_pkg::ADR_W-1:0] regIdx;
	logic [pfi_pkg::DAT_W-1:0] wrMask;
	logic [pfi_pkg::DAT_W-1:0] wrData;
	logic ack_reg;
	logic [pfi_pkg::DAT_W-1:0] rdData_reg;
	logic [pfi_pkg::DAT_W-1:0] rdData_next;

	// A request is taken once; the ack cycle blocks a second take.
	assign busReq = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wrStrobe = busReq & wb_we_i;
	assign regIdx = wb_adr_i[pfi_pkg::ADR_LSB +: pfi_pkg::ADR_W];
	assign wrMask = laneMask(wb_sel_i);
	assign wrData = wb_dat_i & wrMask;

	logic wrFlagsOne;
	logic wrFlagsTwo;
	logic wrEnOne;
	logic wrEnTwo;
	logic wrEvtEn;
	logic wrEvtClr;

	// Per-register write strobes.
	assign wrFlagsOne = wrStrobe & (regIdx == pfi_pkg::IDX_FLAGS_ONE);
	assign wrFlagsTwo = wrStrobe & (regIdx == pfi_pkg::IDX_FLAGS_TWO);
	assign wrEnOne = wrStrobe & (regIdx == pfi_pkg::IDX_ENABLES_ONE);
	assign wrEnTwo = wrStrobe & (regIdx == pfi_pkg::IDX_ENABLES_TWO);
	assign wrEvtEn = wrStrobe & (regIdx == pfi_pkg::IDX_EVT_ENABLE);
	assign wrEvtClr = wrStrobe & (regIdx == pfi_pkg::IDX_EVT_CLEAR);

	// ----------------------------------------------------------------------
	// Event qualification.
	// ----------------------------------------------------------------------
	logic [pfi_pkg::REG_W-1:0] setOne;
	logic [pfi_pkg::REG_W-1:0] setTwo;
	logic [pfi_pkg::REG_W-1:0] uartLevel;

	// Sticky set sources of the first flag register, independent of enables.
	always_comb begin
		setOne = '0;
		setOne[pfi_pkg::BIT_CONV] = convDoneEvt;
		setOne[pfi_pkg::BIT_SERIAL] = serialDoneEvt;
		setOne[pfi_pkg::BIT_CAPCOMP1] = capComp1Evt & ~capComp1Pwm;
		setOne[pfi_pkg::BIT_PERIOD] = periodMatchEvt;
		setOne[pfi_pkg::BIT_WIDE_OVF] = wideOverflowEvt;
		setOne[pfi_pkg::BIT_SLAVE] = slavePortAccessEvt;
	end

	// Second register has a single source, ignored in PWM mode.
	always_comb begin
		setTwo = '0;
		setTwo[pfi_pkg::BIT_CAPCOMP2] = capComp2Evt & ~capComp2Pwm;
	end

	// Buffer state levels for the read-only uart flags.
	always_comb begin
		uartLevel = '0;
		uartLevel[pfi_pkg::BIT_UART_RX] = uartRxFull;
		uartLevel[pfi_pkg::BIT_UART_TX] = uartTxEmpty;
	end

	// ----------------------------------------------------------------------
	// Flag registers.
	// ----------------------------------------------------------------------
	logic [pfi_pkg::REG_W-1:0] stickyOne;
	logic [pfi_pkg::REG_W-1:0] flagsTwo;
	logic [pfi_pkg::REG_W-1:0] uartFlags_reg;
	logic [pfi_pkg::REG_W-1:0] flagsOne;

	// Software-cleared bits of the first register; uart bits are not writable.
	pfi_sticky_flags #(
		.W(pfi_pkg::REG_W)
	) u_flags_one (
		.clk(clk),
		.reset_n(reset_n),
		.setVec(setOne),
		.implMask(IMPL_ONE & pfi_pkg::SW_CLEARED_MASK),
		.loadEn(wrFlagsOne),
		.loadMask(wrMask[pfi_pkg::REG_W-1:0] & pfi_pkg::SW_CLEARED_MASK),
		.loadVal(wrData[pfi_pkg::REG_W-1:0]),
		.flags(stickyOne)
	);

	// Second flag register, only bit zero exists.
	pfi_sticky_flags #(
		.W(pfi_pkg::REG_W)
	) u_flags_two (
		.clk(clk),
		.reset_n(reset_n),
		.setVec(setTwo),
		.implMask(pfi_pkg::FLAGS_TWO_MASK),
		.loadEn(wrFlagsTwo),
		.loadMask(wrMask[pfi_pkg::REG_W-1:0]),
		.loadVal(wrData[pfi_pkg::REG_W-1:0]),
		.flags(flagsTwo)
	);

	// Uart flags track buffer state and are cleared by the uart itself.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			uartFlags_reg <= pfi_pkg::FLAGS_RESET;
		end else begin
			uartFlags_reg <= uartLevel & IMPL_ONE & pfi_pkg::UART_MASK;
		end
	end

	assign flagsOne = stickyOne | uartFlags_reg;

	// ----------------------------------------------------------------------
	// Enable registers.
	// ----------------------------------------------------------------------
	logic [pfi_pkg::REG_W-1:0] enOne_reg;
	logic [pfi_pkg::REG_W-1:0] enTwo_reg;

	// First enable register, one bit per first-register flag.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			enOne_reg <= pfi_pkg::ENABLES_RESET;
		end else if (wrEnOne) begin
			enOne_reg <= ((enOne_reg & ~wrMask[pfi_pkg::REG_W-1:0]) | wrData[pfi_pkg::REG_W-1:0]) & IMPL_ONE;
		end
	end

	// Second enable register, only the second unit's bit.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			enTwo_reg <= pfi_pkg::ENABLES_RESET;
		end else if (wrEnTwo) begin
			enTwo_reg <= ((enTwo_reg & ~wrMask[pfi_pkg::REG_W-1:0]) | wrData[pfi_pkg::REG_W-1:0])
				& pfi_pkg::FLAGS_TWO_MASK;
		end
	end

	// Peripheral request from both flag and enable pairs.
	pfi_irq_gate #(
		.W(2 * pfi_pkg::REG_W)
	) u_periph_irq (
		.clk(clk),
		.reset_n(reset_n),
		.pending({flagsTwo, flagsOne}),
		.enables({enTwo_reg, enOne_reg}),
		.irq(periphIrq)
	);

	// ----------------------------------------------------------------------
	// Event status, enable and clear.
	// ----------------------------------------------------------------------
	logic [pfi_pkg::EVT_W-1:0] evtStatus;
	logic [pfi_pkg::EVT_W-1:0] evtSet;
	logic [pfi_pkg::EVT_W-1:0] evtClr;
	logic [pfi_pkg::EVT_W-1:0] evtEn_reg;
	logic [pfi_pkg::EVT_W-1:0] evtImpl;

	// Each source edge records a sticky event; the uart bits record level rises.
	assign evtSet = {setTwo[pfi_pkg::BIT_CAPCOMP2], setOne | (uartLevel & ~uartFlags_reg)};
	assign evtImpl = {pfi_pkg::FLAGS_TWO_MASK[pfi_pkg::BIT_CAPCOMP2], IMPL_ONE};
	assign evtClr = wrData[pfi_pkg::EVT_W-1:0];

	// Writing ones to the clear register drops those bits; a set still wins.
	pfi_sticky_flags #(
		.W(pfi_pkg::EVT_W)
	) u_evt_status (
		.clk(clk),
		.reset_n(reset_n),
		.setVec(evtSet),
		.implMask(evtImpl),
		.loadEn(wrEvtClr),
		.loadMask(evtClr),
		.loadVal('0),
		.flags(evtStatus)
	);

	// Event enable register.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			evtEn_reg <= pfi_pkg::EVT_RESET;
		end else if (wrEvtEn) begin
			evtEn_reg <= ((evtEn_reg & ~wrMask[pfi_pkg::EVT_W-1:0]) | wrData[pfi_pkg::EVT_W-1:0]) & evtImpl;
		end
	end

	// Event interrupt line.
	pfi_irq_gate #(
		.W(pfi_pkg::EVT_W)
	) u_evt_irq (
		.clk(clk),
		.reset_n(reset_n),
		.pending(evtStatus),
		.enables(evtEn_reg),
		.irq(eventIrq)
	);

	// ----------------------------------------------------------------------
	// Read path and acknowledge.
	// ----------------------------------------------------------------------
	// Read mux; unmapped and write-only locations read zero.
	always_comb begin
		rdData_next = pfi_pkg::DAT_ZERO;
		case (regIdx)
			pfi_pkg::IDX_FLAGS_ONE: rdData_next[pfi_pkg::REG_W-1:0] = flagsOne;
			pfi_pkg::IDX_FLAGS_TWO: rdData_next[pfi_pkg::REG_W-1:0] = flagsTwo;
			pfi_pkg::IDX_ENABLES_ONE: rdData_next[pfi_pkg::REG_W-1:0] = enOne_reg;
			pfi_pkg::IDX_ENABLES_TWO: rdData_next[pfi_pkg::REG_W-1:0] = enTwo_reg;
			pfi_pkg::IDX_EVT_STATUS: rdData_next[pfi_pkg::EVT_W-1:0] = evtStatus;
			pfi_pkg::IDX_EVT_ENABLE: rdData_next[pfi_pkg::EVT_W-1:0] = evtEn_reg;
			default: rdData_next = pfi_pkg::DAT_ZERO;
		endcase
	end

	// Ack one cycle after the request, dropped the cycle after.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= busReq;
		end
	end

	// Read data is captured with the ack and held until the next read request.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdData_reg <= pfi_pkg::DAT_ZERO;
		end else if (busReq && !wb_we_i) begin
			rdData_reg <= rdData_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdData_reg;

endmodule : pfi_peripheral_interrupt_flags

//--- dv/pfi_flags_checker.sv
// Purpose: Port-level checker for the peripheral interrupt flag block.
// Assumes: One clock domain; reset_n is synchronous and active low.
// Notes: Bound to every instance of the top module, variants included.

`timescale 1ns/10ps

module pfi_flags_checker #(
	parameter bit HAS_SLAVE_PORT = 1'b1,
	parameter bit HAS_UART = 1'b1
) (
	input wire logic clk, // Core clock.
	input wire logic reset_n, // Reset, active low.
	input wire logic wb_cyc_i, // Cycle.
	input wire logic wb_stb_i, // Strobe.
	input wire logic wb_we_i, // Write enable.
	input wire logic [pfi_pkg::ADR_W+1:0] wb_adr_i, // Byte address.
	input wire logic [pfi_pkg::DAT_W-1:0] wb_dat_o, // Read data.
	input wire logic wb_ack_o, // Acknowledge.
	input wire logic convDoneEvt, // Event.
	input wire logic serialDoneEvt, // Event.
	input wire logic capComp1Evt, // Event.
	input wire logic periodMatchEvt, // Event.
	input wire logic wideOverflowEvt, // Event.
	input wire logic slavePortAccessEvt, // Event.
	input wire logic capComp2Evt, // Event.
	input wire logic uartRxFull, // Level.
	input wire logic uartTxEmpty, // Level.
	input wire logic periphIrq, // Request.
	input wire logic eventIrq // Event request.
);
	// ----------
	// Helpers
	// ----------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic take;
	logic anyEvt;
	// A request is taken while the strobe is up and no answer stands.
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign anyEvt = convDoneEvt || serialDoneEvt || capComp1Evt || periodMatchEvt || wideOverflowEvt
		|| slavePortAccessEvt || capComp2Evt || uartRxFull || uartTxEmpty || (take && wb_we_i);
	sequence s_read(logic [7:0] idx);
		wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) >> 2) == idx;
	endsequence
	// ----------
	// Properties
	// ----------
	property p_ack_next; take |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing one cycle after a request");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
	property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without a request");
	property p_reset_state;
		disable iff (1'b0) !reset_n |=> (wb_dat_o == '0 && !wb_ack_o && !periphIrq && !eventIrq);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("outputs not cleared by reset");
	property p_dat_hold; !(take && !wb_we_i) |=> $stable(wb_dat_o); endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data changed without a read");
	property p_uart_bits;
		s_read(pfi_pkg::IDX_FLAGS_ONE) |-> (HAS_SLAVE_PORT || !wb_dat_o[7]) && wb_dat_o[5:4] ==
			(HAS_UART ? {$past(uartRxFull, 2), $past(uartTxEmpty, 2)} : 2'b00);
	endproperty
	a_uart_bits: assert property (p_uart_bits) else $error("uart or slave bits wrong");
	property p_two_upper; s_read(pfi_pkg::IDX_FLAGS_TWO) |-> wb_dat_o[31:1] == '0; endproperty
	a_two_upper: assert property (p_two_upper) else $error("second flag upper bits not zero");
	property p_unmapped; s_read(8'h00) |-> wb_dat_o == '0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_irq_cause;
		$rose(periphIrq) |-> $past(anyEvt, 2);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("request rose without a cause");
	c_read: cover property (s_read(pfi_pkg::IDX_FLAGS_ONE));
	c_irq: cover property ($rose(periphIrq));
	c_eirq: cover property ($rose(eventIrq));
endmodule : pfi_flags_checker

bind pfi_peripheral_interrupt_flags pfi_flags_checker #(.HAS_SLAVE_PORT(HAS_SLAVE_PORT), .HAS_UART(HAS_UART)) chk (
	.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .convDoneEvt,
	.serialDoneEvt, .capComp1Evt, .periodMatchEvt, .wideOverflowEvt, .slavePortAccessEvt, .capComp2Evt,
	.uartRxFull, .uartTxEmpty, .periphIrq, .eventIrq);

//--- dv/pfi_periph_model.sv
// Purpose: Model of the peripherals that feed the flag block.
// Assumes: Requests come from the bench on the core clock.
// Notes: Each request is passed on one cycle late for as long as it is held; the uart lines are levels.

`timescale 1ns/10ps

module pfi_periph_model (
	input wire logic clk, // Core clock.
	input wire logic reset_n, // Reset, active low.
	input wire logic [8:0] fire, // Event requests, event status layout.
	input wire logic rxIn, // Receive buffer holds data.
	input wire logic txIn, // Transmit buffer empty.
	output logic convDoneEvt, // Conversion done.
	output logic serialDoneEvt, // Serial transfer done.
	output logic capComp1Evt, // First unit event.
	output logic periodMatchEvt, // Period match.
	output logic wideOverflowEvt, // Wide timer overflow.
	output logic slavePortAccessEvt, // Slave port access.
	output logic capComp2Evt, // Second unit event.
	output logic uartRxFull, // Receive level.
	output logic uartTxEmpty // Transmit level.
);
	logic [8:0] pulse_reg;
	// Requests are registered so pulses leave just after an edge.
	always_ff @(posedge clk) begin
		pulse_reg <= reset_n ? fire : 9'h000;
		uartRxFull <= reset_n & rxIn;
		uartTxEmpty <= reset_n & txIn;
	end
	// Pulses are spread onto the individual event lines.
	assign wideOverflowEvt = pulse_reg[pfi_pkg::BIT_WIDE_OVF];
	assign periodMatchEvt = pulse_reg[pfi_pkg::BIT_PERIOD];
	assign capComp1Evt = pulse_reg[pfi_pkg::BIT_CAPCOMP1];
	assign serialDoneEvt = pulse_reg[pfi_pkg::BIT_SERIAL];
	assign convDoneEvt = pulse_reg[pfi_pkg::BIT_CONV];
	assign slavePortAccessEvt = pulse_reg[pfi_pkg::BIT_SLAVE];
	assign capComp2Evt = pulse_reg[pfi_pkg::BIT_EVT_CAPCOMP2];
endmodule : pfi_periph_model

//--- dv/pfi_peripheral_interrupt_flags_tb_top.sv
// Purpose: Self-checking bench for the peripheral interrupt flag block.
// Assumes: Full block beside a variant without slave port and uart, on one bus.
// Notes: Both instances take every write; reads compare both answers.

`timescale 1ns/10ps

module pfi_peripheral_interrupt_flags_tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, dat2, rd, rd2;
	logic wb_ack_o, ack2, periphIrq, eventIrq, irq2, eirq2, uartRxFull, uartTxEmpty;
	logic convDoneEvt, serialDoneEvt, capComp1Evt, periodMatchEvt, wideOverflowEvt, slavePortAccessEvt, capComp2Evt;
	logic capComp1Pwm = 1'b0, capComp2Pwm = 1'b0, rxIn = 1'b0, txIn = 1'b0;
	logic [8:0] fire = 9'h000;
	int failures = 0, checks = 0, cycles = 0;

	pfi_peripheral_interrupt_flags uut (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .convDoneEvt, .serialDoneEvt, .capComp1Evt, .capComp1Pwm, .periodMatchEvt,
		.wideOverflowEvt, .slavePortAccessEvt, .uartRxFull, .uartTxEmpty, .capComp2Evt, .capComp2Pwm, .periphIrq,
		.eventIrq);
	pfi_peripheral_interrupt_flags #(.HAS_SLAVE_PORT(1'b0), .HAS_UART(1'b0)) uut2 (.clk, .reset_n, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(dat2), .wb_ack_o(ack2), .convDoneEvt,
		.serialDoneEvt, .capComp1Evt, .capComp1Pwm, .periodMatchEvt, .wideOverflowEvt, .slavePortAccessEvt,
		.uartRxFull, .uartTxEmpty, .capComp2Evt, .capComp2Pwm, .periphIrq(irq2), .eventIrq(eirq2));
	pfi_periph_model periph (.clk, .reset_n, .fire, .rxIn, .txIn, .convDoneEvt, .serialDoneEvt, .capComp1Evt,
		.periodMatchEvt, .wideOverflowEvt, .slavePortAccessEvt, .capComp2Evt, .uartRxFull, .uartTxEmpty);

	// ----------
	// Shared tasks
	// ----------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		rd2 = dat2;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus
	task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] e, input logic [31:0] e2);
		bus(1'b0, idx, 32'h0);
		chk(name, rd, e);
		chk({name, "_variant"}, rd2, e2);
	endtask : rdchk
	task automatic pulse(input logic [8:0] v);
		@(posedge clk);
		fire <= v;
		@(posedge clk);
		fire <= 9'h000;
		repeat (3) @(posedge clk);
	endtask : pulse

	// ----------
	// Scenarios
	// ----------
	task automatic t_reset();
		rdchk("flags_one", pfi_pkg::IDX_FLAGS_ONE, 32'h0, 32'h0);
		rdchk("flags_two", pfi_pkg::IDX_FLAGS_TWO, 32'h0, 32'h0);
		rdchk("enables_two", pfi_pkg::IDX_ENABLES_TWO, 32'h0, 32'h0);
		chk("irq", 32'(periphIrq), 32'h0);
	endtask : t_reset
	task automatic t_events();
		int bits[6] = '{pfi_pkg::BIT_WIDE_OVF, pfi_pkg::BIT_PERIOD, pfi_pkg::BIT_CAPCOMP1, pfi_pkg::BIT_SERIAL,
			pfi_pkg::BIT_CONV, pfi_pkg::BIT_SLAVE};
		logic [31:0] m;
		foreach (bits[i]) begin
			m = 32'h1 << bits[i];
			pulse(9'(m));
			repeat (4) @(posedge clk);
			rdchk("flag_set", pfi_pkg::IDX_FLAGS_ONE, m, (bits[i] == 7) ? 32'h0 : m);
			chk("irq_masked", 32'(periphIrq), 32'h0);
			bus(1'b1, pfi_pkg::IDX_FLAGS_ONE, 32'h0);
			rdchk("flag_clear", pfi_pkg::IDX_FLAGS_ONE, 32'h0, 32'h0);
		end
	endtask : t_events
	task automatic t_irq();
		pulse(9'h004);
		bus(1'b1, pfi_pkg::IDX_ENABLES_ONE, 32'hff);
		rdchk("enables_one", pfi_pkg::IDX_ENABLES_ONE, 32'hff, 32'h4f);
		repeat (2) @(posedge clk);
		chk("irq_stale", 32'(periphIrq), 32'h1);
		bus(1'b1, pfi_pkg::IDX_FLAGS_ONE, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq_cleared", 32'(periphIrq), 32'h0);
		bus(1'b1, pfi_pkg::IDX_ENABLES_ONE, 32'h0);
		pulse(9'h100);
		rdchk("flags_two", pfi_pkg::IDX_FLAGS_TWO, 32'h1, 32'h1);
		chk("irq_two_off", 32'(periphIrq), 32'h0);
		bus(1'b1, pfi_pkg::IDX_ENABLES_TWO, 32'hff);
		rdchk("enables_two", pfi_pkg::IDX_ENABLES_TWO, 32'h1, 32'h1);
		chk("irq_two_on", 32'(periphIrq), 32'h1);
		bus(1'b1, pfi_pkg::IDX_FLAGS_TWO, 32'hfe);
		rdchk("flags_two_clr", pfi_pkg::IDX_FLAGS_TWO, 32'h0, 32'h0);
		bus(1'b1, pfi_pkg::IDX_ENABLES_TWO, 32'h0);
	endtask : t_irq
	task automatic t_pwm();
		@(posedge clk);
		capComp1Pwm <= 1'b1;
		capComp2Pwm <= 1'b1;
		pulse(9'h104);
		rdchk("pwm_one", pfi_pkg::IDX_FLAGS_ONE, 32'h0, 32'h0);
		rdchk("pwm_two", pfi_pkg::IDX_FLAGS_TWO, 32'h0, 32'h0);
		capComp1Pwm <= 1'b0;
		capComp2Pwm <= 1'b0;
	endtask : t_pwm
	task automatic t_uart();
		rxIn <= 1'b1;
		repeat (4) @(posedge clk);
		rdchk("rx_full", pfi_pkg::IDX_FLAGS_ONE, 32'h20, 32'h0);
		bus(1'b1, pfi_pkg::IDX_FLAGS_ONE, 32'h0);
		rdchk("rx_held", pfi_pkg::IDX_FLAGS_ONE, 32'h20, 32'h0);
		rxIn <= 1'b0;
		txIn <= 1'b1;
		repeat (4) @(posedge clk);
		rdchk("tx_empty", pfi_pkg::IDX_FLAGS_ONE, 32'h10, 32'h0);
		txIn <= 1'b0;
		repeat (4) @(posedge clk);
		rdchk("tx_full", pfi_pkg::IDX_FLAGS_ONE, 32'h0, 32'h0);
	endtask : t_uart
	task automatic t_evt();
		bus(1'b1, pfi_pkg::IDX_EVT_CLEAR, 32'h1ff);
		bus(1'b1, pfi_pkg::IDX_EVT_ENABLE, 32'h001);
		pulse(9'h001);
		chk("event_irq", 32'(eventIrq), 32'h1);
		rdchk("event_status", pfi_pkg::IDX_EVT_STATUS, 32'h1, 32'h1);
		bus(1'b1, pfi_pkg::IDX_EVT_CLEAR, 32'h001);
		rdchk("event_cleared", pfi_pkg::IDX_EVT_STATUS, 32'h0, 32'h0);
		chk("event_irq_low", 32'(eventIrq), 32'h0);
		bus(1'b1, pfi_pkg::IDX_EVT_ENABLE, 32'h0);
		pulse(9'h001);
		chk("event_masked", 32'(eventIrq), 32'h0);
		rdchk("event_sticky", pfi_pkg::IDX_EVT_STATUS, 32'h1, 32'h1);
		rdchk("clear_reads", pfi_pkg::IDX_EVT_CLEAR, 32'h0, 32'h0);
		bus(1'b1, 8'h00, 32'hffff_ffff);
		rdchk("unmapped", 8'h00, 32'h0, 32'h0);
	endtask : t_evt
	task automatic t_mid_reset();
		pulse(9'h1cf);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		rdchk("mid_one", pfi_pkg::IDX_FLAGS_ONE, 32'h0, 32'h0);
		rdchk("mid_two", pfi_pkg::IDX_FLAGS_TWO, 32'h0, 32'h0);
	endtask : t_mid_reset
	task automatic results();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	// ----------
	// Clock, timeout and main sequence
	// ----------
	// Free-running 250 MHz clock.
	initial begin
		forever #2 clk = ~clk;
	end
	// Cuts a hang short well beyond the expected run length.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			results();
		end
	end
	// Reset, then every scenario in turn.
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_events();
		t_irq();
		t_pwm();
		t_uart();
		t_evt();
		t_mid_reset();
		results();
	end
endmodule : pfi_peripheral_interrupt_flags_tb_top
